// ==== pkg/pmh_cfg.svh ====
`ifndef PMH_CFG_SVH
`define PMH_CFG_SVH

// ***********************************************
// shared memory layout, word offsets
// ***********************************************
`define PMH_RESP_BASE 16'h0000
`define PMH_REQ_BASE 16'h01F4
`define PMH_OFS_READ 16'h0000
`define PMH_OFS_SET 16'h0001
`define PMH_OFS_CMD 16'h0002
`define PMH_OFS_STATUS 16'h0003
`define PMH_OFS_CODE 16'h0003
`define PMH_OFS_DATA 16'h0004

// ***********************************************
// request word values
// ***********************************************
`define PMH_REQ_STOP 16'h0000
`define PMH_REQ_SINGLE 16'h0001
`define PMH_REQ_MULTI 16'h0002
`define PMH_REQ_RDSET 16'h0003

// ***********************************************
// status word, last step indices, reset values
// ***********************************************
`define PMH_LIVE_BIT 15
`define PMH_LAST_PARAM 3'h3
`define PMH_LAST_POLL 3'h3
`define PMH_LAST_RESP 3'h2
`define PMH_SETVAL_RST 16'h0000
`define PMH_CODE_RST 16'h0000

`endif

// ==== pkg/pmh_pkg.sv ====
package pmh_pkg;

    typedef enum logic [2:0] {
        PH_POLL,
        PH_RESP,
        PH_UPL,
        PH_DNL,
        PH_CMD,
        PH_STAT
    } pmh_phase_t;

    typedef enum logic [2:0] {
        CH_IDLE,
        CH_SINGLE,
        CH_HELD,
        CH_MULTI,
        CH_STOPPING
    } pmh_chan_t;

endpackage : pmh_pkg

// ==== rtl/pmh_chan.sv ====
`include "pmh_cfg.svh"

module pmh_chan
    import pmh_pkg::*;
#(
    parameter logic ALLOW_RDSET = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic poll_i,
    input wire logic [15:0] req_i,
    input wire logic done_i,
    output logic run_o,
    output logic [15:0] mode_o,
    output logic [15:0] resp_o
);

    pmh_chan_t st_q;
    logic [15:0] resp_q;
    logic [15:0] mode_q;
    logic start_single;

    assign start_single = (req_i == `PMH_REQ_SINGLE) ||
                          (ALLOW_RDSET && (req_i == `PMH_REQ_RDSET));

    // ***********************************************
    // handshake state per request word
    // ***********************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= CH_IDLE;
            resp_q <= `PMH_REQ_STOP;
            mode_q <= `PMH_REQ_STOP;
        end else begin
            case (st_q)
                CH_IDLE: begin
                    if (poll_i && start_single) begin
                        mode_q <= req_i;
                        st_q <= CH_SINGLE;
                    end else if (poll_i && req_i == `PMH_REQ_MULTI) begin
                        // echo before the first repeat
                        resp_q <= req_i;
                        mode_q <= req_i;
                        st_q <= CH_MULTI;
                    end
                end
                CH_SINGLE: begin
                    if (done_i) begin
                        resp_q <= mode_q;
                        st_q <= CH_HELD;
                    end
                end
                CH_HELD: begin
                    // nonzero values here are ignored until a zero
                    if (poll_i && req_i == `PMH_REQ_STOP) begin
                        resp_q <= `PMH_REQ_STOP;
                        st_q <= CH_IDLE;
                    end
                end
                CH_MULTI: begin
                    if (poll_i && req_i == `PMH_REQ_STOP) begin
                        st_q <= CH_STOPPING;
                    end
                end
                CH_STOPPING: begin
                    if (done_i) begin
                        resp_q <= `PMH_REQ_STOP;
                        st_q <= CH_IDLE;
                    end
                end
                default: begin
                    st_q <= CH_IDLE;
                end
            endcase
        end
    end

    assign run_o = (st_q == CH_SINGLE) || (st_q == CH_MULTI);
    assign mode_o = mode_q;
    assign resp_o = resp_q;

    single_ack_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CH_SINGLE && done_i) |=> (resp_q == $past(mode_q))
            && (st_q == CH_HELD))
        else $error("single ack not copied after action");

    multi_echo_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CH_IDLE && poll_i && req_i == `PMH_REQ_MULTI)
            |=> (resp_q == `PMH_REQ_MULTI) && run_o)
        else $error("multi request not echoed first");

    no_direct_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CH_HELD && poll_i && req_i != `PMH_REQ_STOP)
            |=> (st_q == CH_HELD) && $stable(resp_q))
        else $error("request accepted without passing zero");

    stop_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CH_STOPPING && done_i) |=> (resp_q == `PMH_REQ_STOP))
        else $error("response not cleared after stop");

endmodule : pmh_chan

// ==== rtl/pmh_top.sv ====
`include "pmh_cfg.svh"

module pmh_top
    import pmh_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_ack_i,
    input wire logic [63:0] mon_vals_i,
    output logic param_wr_o,
    output logic [1:0] param_idx_o,
    output logic [15:0] param_val_o,
    output logic cmd_exec_o,
    output logic [15:0] cmd_code_o,
    output logic live_o
);

    // ***********************************************
    // declarations
    // ***********************************************
    pmh_phase_t phase_q;
    logic [2:0] step_q;
    logic mem_req_q;
    logic mem_we_q;
    logic [15:0] mem_addr_q;
    logic [15:0] mem_wdata_q;
    logic poll_q, done_q, live_q;
    logic [15:0] req_rd_q, req_set_q, req_cmd_q;
    logic [15:0] code_q;
    logic [15:0] set_val_q [4];
    logic [15:0] shadow_q [4];
    logic param_wr_q;
    logic [1:0] param_idx_q;
    logic [15:0] param_val_q;
    logic cmd_exec_q;
    logic [15:0] cmd_code_q;
    logic [15:0] last_code_q;
    logic cmd_fresh_q;
    logic [2:0] ch_run;
    logic [15:0] rd_mode, cmd_mode;
    logic [15:0] rd_resp, set_resp, cmd_resp;
    logic [15:0] resp_sel;
    logic [15:0] upl_word;
    logic xfer_done;

    // ***********************************************
    // helpers
    // ***********************************************
    function automatic logic [15:0] word_addr(input logic [15:0] base,
                                              input logic [15:0] ofs);
        word_addr = base + ofs;
    endfunction : word_addr

    function automatic logic [15:0] step_ofs(input logic [15:0] ofs,
                                             input logic [2:0] step);
        step_ofs = ofs + {13'h0000, step};
    endfunction : step_ofs

    function automatic logic [15:0] mon_word(input logic [63:0] vec,
                                             input logic [1:0] idx);
        mon_word = vec[{idx, 4'h0} +: 16];
    endfunction : mon_word

    assign xfer_done = mem_req_q && mem_ack_i;

    // ***********************************************
    // request trackers, one per request word
    // ***********************************************
    // each tracker owns exactly one response word
    pmh_chan #(.ALLOW_RDSET(1'b1)) u_rd_chan (
        .clk_i(clk_i), .rst_i(rst_i), .poll_i(poll_q),
        .req_i(req_rd_q), .done_i(done_q), .run_o(ch_run[0]),
        .mode_o(rd_mode), .resp_o(rd_resp)
    );

    pmh_chan #(.ALLOW_RDSET(1'b0)) u_set_chan (
        .clk_i(clk_i), .rst_i(rst_i), .poll_i(poll_q),
        .req_i(req_set_q), .done_i(done_q), .run_o(ch_run[1]),
        .mode_o(), .resp_o(set_resp)
    );

    pmh_chan #(.ALLOW_RDSET(1'b0)) u_cmd_chan (
        .clk_i(clk_i), .rst_i(rst_i), .poll_i(poll_q),
        .req_i(req_cmd_q), .done_i(done_q), .run_o(ch_run[2]),
        .mode_o(cmd_mode), .resp_o(cmd_resp)
    );

    assign resp_sel = (step_q == 3'h0) ? rd_resp :
                      (step_q == 3'h1) ? set_resp : cmd_resp;

    // read-setting mode returns the device's own set values
    assign upl_word = (rd_mode == `PMH_REQ_RDSET) ?
                      set_val_q[step_q[1:0]] :
                      mon_word(mon_vals_i, step_q[1:0]);

    // ***********************************************
    // round sequencer and memory port
    // ***********************************************
    // one access outstanding; responses go out before the actions so
    // a multi echo lands first and a single echo lands after its round
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= PH_POLL;
            step_q <= 3'h0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_wdata_q <= 16'h0000;
            poll_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            poll_q <= 1'b0;
            done_q <= 1'b0;
            if (!mem_req_q) begin
                case (phase_q)
                    PH_POLL: begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_addr_q <= word_addr(`PMH_REQ_BASE,
                            step_ofs(`PMH_OFS_READ, step_q));
                    end
                    PH_RESP: begin
                        // wait out the poll pulse so a fresh echo is sent
                        if (!poll_q) begin
                            mem_req_q <= 1'b1;
                            mem_we_q <= 1'b1;
                            mem_addr_q <= word_addr(`PMH_RESP_BASE,
                                step_ofs(`PMH_OFS_READ, step_q));
                            mem_wdata_q <= resp_sel;
                        end
                    end
                    PH_UPL: begin
                        if (ch_run[0]) begin
                            mem_req_q <= 1'b1;
                            mem_we_q <= 1'b1;
                            mem_addr_q <= word_addr(`PMH_RESP_BASE,
                                step_ofs(`PMH_OFS_DATA, step_q));
                            mem_wdata_q <= upl_word;
                        end else begin
                            phase_q <= PH_DNL;
                            step_q <= 3'h0;
                        end
                    end
                    PH_DNL: begin
                        if (ch_run[1]) begin
                            mem_req_q <= 1'b1;
                            mem_we_q <= 1'b0;
                            mem_addr_q <= word_addr(`PMH_REQ_BASE,
                                step_ofs(`PMH_OFS_DATA, step_q));
                        end else begin
                            phase_q <= PH_CMD;
                            step_q <= 3'h0;
                        end
                    end
                    PH_CMD: begin
                        // the round's actions are complete here
                        done_q <= 1'b1;
                        phase_q <= PH_STAT;
                    end
                    PH_STAT: begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b1;
                        mem_addr_q <= word_addr(`PMH_RESP_BASE,
                                                `PMH_OFS_STATUS);
                        mem_wdata_q <= {~live_q, 15'h0000};
                    end
                    default: begin
                        phase_q <= PH_POLL;
                        step_q <= 3'h0;
                    end
                endcase
            end else if (mem_ack_i) begin
                mem_req_q <= 1'b0;
                case (phase_q)
                    PH_POLL: begin
                        if (step_q == `PMH_LAST_POLL) begin
                            poll_q <= 1'b1;
                            phase_q <= PH_RESP;
                            step_q <= 3'h0;
                        end else begin
                            step_q <= step_q + 3'h1;
                        end
                    end
                    PH_RESP: begin
                        if (step_q == `PMH_LAST_RESP) begin
                            phase_q <= PH_UPL;
                            step_q <= 3'h0;
                        end else begin
                            step_q <= step_q + 3'h1;
                        end
                    end
                    PH_UPL, PH_DNL: begin
                        if (step_q == `PMH_LAST_PARAM) begin
                            phase_q <= (phase_q == PH_UPL) ? PH_DNL : PH_CMD;
                            step_q <= 3'h0;
                        end else begin
                            step_q <= step_q + 3'h1;
                        end
                    end
                    default: begin
                        phase_q <= PH_POLL;
                        step_q <= 3'h0;
                    end
                endcase
            end
        end
    end

    // ***********************************************
    // polled request and code words
    // ***********************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_rd_q <= `PMH_REQ_STOP;
            req_set_q <= `PMH_REQ_STOP;
            req_cmd_q <= `PMH_REQ_STOP;
            code_q <= `PMH_CODE_RST;
        end else if (xfer_done && phase_q == PH_POLL) begin
            case (step_q)
                3'h0: req_rd_q <= mem_rdata_i;
                3'h1: req_set_q <= mem_rdata_i;
                3'h2: req_cmd_q <= mem_rdata_i;
                default: code_q <= mem_rdata_i;
            endcase
        end
    end

    // ***********************************************
    // set values, changed-only apply
    // ***********************************************
    // monitor words are only ever written, so controller edits there
    // cannot reach the set values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                set_val_q[i] <= `PMH_SETVAL_RST;
                shadow_q[i] <= `PMH_SETVAL_RST;
            end
            param_wr_q <= 1'b0;
            param_idx_q <= 2'h0;
            param_val_q <= 16'h0000;
        end else begin
            param_wr_q <= 1'b0;
            if (xfer_done && phase_q == PH_DNL &&
                mem_rdata_i != shadow_q[step_q[1:0]]) begin
                shadow_q[step_q[1:0]] <= mem_rdata_i;
                set_val_q[step_q[1:0]] <= mem_rdata_i;
                param_wr_q <= 1'b1;
                param_idx_q <= step_q[1:0];
                param_val_q <= mem_rdata_i;
            end
        end
    end

    // ***********************************************
    // operation command execution
    // ***********************************************
    // a fresh request always executes, even with an unchanged code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_exec_q <= 1'b0;
            cmd_code_q <= `PMH_CODE_RST;
            last_code_q <= `PMH_CODE_RST;
            cmd_fresh_q <= 1'b1;
        end else begin
            cmd_exec_q <= 1'b0;
            if (!ch_run[2]) begin
                cmd_fresh_q <= 1'b1;
            end else if (phase_q == PH_CMD && !mem_req_q &&
                         (cmd_mode == `PMH_REQ_SINGLE || cmd_fresh_q ||
                          code_q != last_code_q)) begin
                cmd_exec_q <= 1'b1;
                cmd_code_q <= code_q;
                last_code_q <= code_q;
                cmd_fresh_q <= 1'b0;
            end
        end
    end

    // ***********************************************
    // liveness toggle
    // ***********************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live_q <= 1'b0;
        end else if (xfer_done && phase_q == PH_STAT) begin
            live_q <= ~live_q;
        end
    end

    assign mem_req_o = mem_req_q;
    assign mem_we_o = mem_we_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_wdata_o = mem_wdata_q;
    assign param_wr_o = param_wr_q;
    assign param_idx_o = param_idx_q;
    assign param_val_o = param_val_q;
    assign cmd_exec_o = cmd_exec_q;
    assign cmd_code_o = cmd_code_q;
    assign live_o = live_q;

    // ***********************************************
    // checks
    // ***********************************************
    live_flip_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (xfer_done && phase_q == PH_STAT) |=> (live_o != $past(live_o))
            && (phase_q == PH_POLL))
        else $error("status bit did not toggle on exchange end");

    status_word_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (mem_req_o && mem_we_o && phase_q == PH_STAT) |->
            (mem_wdata_o[`PMH_LIVE_BIT] == ~live_o))
        else $error("status word bit 15 wrong");

    upload_gate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (mem_req_o && phase_q == PH_UPL) |-> (mem_we_o && ch_run[0]))
        else $error("upload write without active read request");

    cmd_gate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cmd_exec_o |-> ch_run[2] && (cmd_code_o == code_q))
        else $error("command executed without request");

    param_gate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        param_wr_o |-> ch_run[1] && (set_val_q[param_idx_o] == param_val_o))
        else $error("set value applied without request");

    poll_order_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        poll_q |-> $past(mem_addr_o) == word_addr(`PMH_REQ_BASE,
                                                  `PMH_OFS_CODE))
        else $error("round started without reading code word");

endmodule : pmh_top

// ==== sim/pmh_plc_model.sv ====
// ***********************************************
// controller memory: shared request/response words
// ***********************************************
module pmh_plc_model (
    input wire logic clk_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    input wire logic [3:0] lat_i,
    output logic [15:0] mem_rdata_o,
    output logic mem_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:511];
    logic [3:0] wait_q = 4'h0;
    initial foreach (mem[i]) mem[i] = 16'h0000;
    // lat_i stretches the answer to model a slow scan
    assign mem_ack_o = mem_req_i && (wait_q >= lat_i);
    // outside an ack the lines show the inverse, never a stale word
    assign mem_rdata_o = mem_ack_o ? mem[mem_addr_i[8:0]]
                                   : ~mem[mem_addr_i[8:0]];
    always @(posedge clk_i) begin
        wait_q <= (mem_req_i && !mem_ack_o) ? wait_q + 4'h1 : 4'h0;
        if (mem_ack_o && mem_we_i) begin
            mem[mem_addr_i[8:0]] <= mem_wdata_i;
        end
    end
endmodule : pmh_plc_model

// ==== sim/tb_plc_memory_handshake.sv ====
`include "pmh_cfg.svh"
module tb_plc_memory_handshake import pmh_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
 $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
    localparam int RQ = `PMH_REQ_BASE;
    logic clk_i = 1'b0, rst_i = 1'b1, req, we, ack, wr, ex, live, live_q;
    logic [15:0] addr, wdata, rdata, val, code;
    logic [63:0] mon = 64'h0;
    logic [1:0] idx;
    logic [3:0] lat = 4'h0;
    int n_errors = 0, n_tests = 0, n_wr = 0, n_cmd = 0, n_live = 0, n0;
    always #4 clk_i = ~clk_i;
    pmh_top DUT (.clk_i(clk_i), .rst_i(rst_i), .mem_req_o(req),
        .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wdata),
        .mem_rdata_i(rdata), .mem_ack_i(ack), .mon_vals_i(mon),
        .param_wr_o(wr), .param_idx_o(idx), .param_val_o(val),
        .cmd_exec_o(ex), .cmd_code_o(code), .live_o(live));
    pmh_plc_model PLC (.clk_i(clk_i), .mem_req_i(req), .mem_we_i(we),
        .mem_addr_i(addr), .mem_wdata_i(wdata), .lat_i(lat),
        .mem_rdata_o(rdata), .mem_ack_o(ack));
    always @(posedge clk_i) begin
        live_q <= live;
        if (!rst_i && live !== live_q) n_live++;
        if (wr === 1'b1) n_wr++;
        if (ex === 1'b1) n_cmd++;
    end
    // ***********************************************
    // access tasks
    // ***********************************************
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task automatic put(input int a, input logic [15:0] v);
        @(posedge clk_i);
        PLC.mem[a] <= v;
    endtask : put
    task automatic wait_resp(input int a, input logic [15:0] v);
        int i;
        for (i = 0; i < 3000 && PLC.mem[a] !== v; i++) @(negedge clk_i);
        `CHK("response word", v, PLC.mem[a])
        if (i == 3000) results();
    endtask : wait_resp
    task automatic rounds(input int n);
        int s, i;
        s = n_live;
        for (i = 0; i < 5000 && n_live < s + n; i++) @(negedge clk_i);
        if (i == 5000) begin
            n_errors++;
            results();
        end
    endtask : rounds
    // ***********************************************
    // tests
    // ***********************************************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        mon <= 64'h0004_0003_0002_03E8;
        put(4, 16'hFFFF);
        rounds(2);
        `CHK("no set from monitor", 0, n_wr)
        `CHK("live status", n_live[0], PLC.mem[3][15])
        put(RQ, 16'h0001);
        wait_resp(0, 16'h0001);
        for (int k = 0; k < 4; k++)
            `CHK("upload word", mon[16*k+:16], PLC.mem[4+k])
        @(posedge clk_i);
        mon <= 64'h1111_2222_3333_4444;
        put(RQ, 16'h0002);
        rounds(3);
        `CHK("jump ignored", 16'h03E8, PLC.mem[4])
        `CHK("echo kept", 16'h0001, PLC.mem[0])
        put(RQ, 16'h0000);
        wait_resp(0, 16'h0000);
        $display("done single read");
        lat <= 4'h3;
        put(RQ, 16'h0002);
        wait_resp(0, 16'h0002);
        `CHK("echo first", 16'h03E8, PLC.mem[4])
        @(posedge clk_i);
        mon <= 64'h5555_6666_7777_8888;
        rounds(2);
        `CHK("multi upload", 16'h8888, PLC.mem[4])
        `CHK("multi upload", 16'h5555, PLC.mem[7])
        put(RQ, 16'h0000);
        wait_resp(0, 16'h0000);
        $display("done multi read");
        lat <= 4'h1;
        put(RQ + 4, 16'h0010);
        put(RQ + 6, 16'h0030);
        put(RQ + 1, 16'h0001);
        wait_resp(1, 16'h0001);
        `CHK("set writes", 2, n_wr)
        `CHK("set index", 2'h2, idx)
        `CHK("set value", 16'h0030, val)
        put(RQ + 1, 16'h0000);
        wait_resp(1, 16'h0000);
        put(RQ, 16'h0003);
        wait_resp(0, 16'h0003);
        `CHK("read setting", 16'h0010, PLC.mem[4])
        `CHK("read setting", 16'h0000, PLC.mem[5])
        `CHK("read setting", 16'h0030, PLC.mem[6])
        put(RQ, 16'h0000);
        wait_resp(0, 16'h0000);
        put(RQ + 1, 16'h0002);
        wait_resp(1, 16'h0002);
        put(RQ + 5, 16'h0020);
        rounds(3);
        `CHK("multi set", 3, n_wr)
        `CHK("multi set index", 2'h1, idx)
        put(RQ + 1, 16'h0000);
        wait_resp(1, 16'h0000);
        $display("done settings");
        put(RQ + 3, 16'h0ABC);
        put(RQ + 2, 16'h0001);
        wait_resp(2, 16'h0001);
        rounds(2);
        `CHK("single command", 1, n_cmd)
        `CHK("command code", 16'h0ABC, code)
        put(RQ + 2, 16'h0000);
        wait_resp(2, 16'h0000);
        put(RQ + 2, 16'h0002);
        wait_resp(2, 16'h0002);
        rounds(2);
        `CHK("multi first", 2, n_cmd)
        put(RQ + 3, 16'h0BCD);
        rounds(3);
        `CHK("code change", 3, n_cmd)
        `CHK("command code", 16'h0BCD, code)
        put(RQ + 2, 16'h0000);
        wait_resp(2, 16'h0000);
        `CHK("stopped", 3, n_cmd)
        $display("done commands");
        results();
    end
endmodule : tb_plc_memory_handshake
